// ===== pcc_pkg.sv
`default_nettype none
package pcc_pkg;
  localparam int DATA_W = 24;
  localparam int SYNC_W = DATA_W + 4;
  localparam int LINE_W = 12;
  localparam int BYTE_LO = 2;
  localparam int BYTE_HI = 9;
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int MCLK_PERIOD_NS = 80;
  localparam int MCLK_HALF_CYC = (MCLK_PERIOD_NS / 2 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [7:0] MCLK_HALF_M1 = 8'(MCLK_HALF_CYC - 1);
  localparam logic [7:0] CCIR_PREAMBLE = 8'hff;
  localparam logic [1:0] CCIR_SKIP = 2'h3;
  localparam logic [1:0] RESET_CNT = 2'h0;
  localparam logic [DATA_W-1:0] RESET_PIX = 24'h000000;

  typedef enum logic [3:0] {
    PCC_FMT_RAW8,
    PCC_FMT_GENERIC10,
    PCC_FMT_CCIR656,
    PCC_FMT_YCC422_2C,
    PCC_FMT_YCC422_1C,
    PCC_FMT_RGB565_1C,
    PCC_FMT_RGB888_3C,
    PCC_FMT_RGB888_1C,
    PCC_FMT_TVDEC_1C
  } pcc_fmt_e;
endpackage : pcc_pkg
`default_nettype wire

// ===== pcc_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcc_sync_if #(parameter int DW = 24);
  logic pclk;
  logic lsync;
  logic fsync;
  logic field;
  logic [DW-1:0] data;
  modport src (output pclk, output lsync, output fsync, output field, output data);
  modport dst (input pclk, input lsync, input fsync, input field, input data);
endinterface : pcc_sync_if
`default_nettype wire

// ===== pcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_sync #(
  parameter int W = 28
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  pcc_sync_if.src s
);
  logic [W-1:0] q1_q;
  logic [W-1:0] q2_q;
  logic [W-1:0] q3_q;
  logic [W-1:0] stable_q;
  logic [W-1:0] agree;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q1_q <= '0;
      q2_q <= '0;
      q3_q <= '0;
    end else begin
      q1_q <= raw;
      q2_q <= q1_q;
      q3_q <= q2_q;
    end
  end

  assign agree = q2_q ~^ q3_q;

  // A bit moves only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stable_q <= '0;
    end else begin
      stable_q <= (agree & q3_q) | (~agree & stable_q);
    end
  end

  assign s.data = stable_q[W-5:0];
  assign s.pclk = stable_q[W-4];
  assign s.lsync = stable_q[W-3];
  assign s.fsync = stable_q[W-2];
  assign s.field = stable_q[W-1];
endmodule : pcc_sync
`default_nettype wire

// ===== pcc_capture.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Accept up to 24 data bits per pixel clock
// R2: Support RGB888, CCIR656, 8-bit YCbCr, raw formats
// R3: 8-bit sensor drives internal bits 9:2
// R4: 10-bit sensor drives bits 9:0 directly
// R5: 16-bit sensor drives 15:0, YCbCr/RGB565 layouts
// R6: 24-bit source drives all bits 23:0
// R7: One-cycle RGB888 and decoder YCbCr component mapping
// R8: Three bytes on 9:2 form one pixel
// R9: CCIR656/two-cycle YCbCr alternate chroma, luma bytes
// R10: Frame sync realigns frame and line counters
// R11: Drive master clock; sensor returns clock, syncs
// R12: Optional field indicator marks interlaced field
// R13: Sample one pixel clock edge, active lines only
// R14: Deliver nothing before first frame sync
module pcc_capture #(
  parameter logic [7:0] MCLK_HALF = pcc_pkg::MCLK_HALF_M1
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PIXEL_CLOCK_IN,
  input wire logic LINE_SYNC,
  input wire logic FRAME_SYNC,
  input wire logic FIELD_INDICATOR,
  input wire logic [pcc_pkg::DATA_W-1:0] SENSOR_DATA,
  input wire pcc_pkg::pcc_fmt_e FORMAT,
  output logic SENSOR_MCLK,
  output logic PIX_VALID,
  output logic [pcc_pkg::DATA_W-1:0] PIX_DATA,
  output logic PIX_FRAME_START,
  output logic PIX_FIELD,
  output logic [pcc_pkg::LINE_W-1:0] PIX_LINE
);
  import pcc_pkg::*;

  pcc_sync_if #(.DW(DATA_W)) sif ();

  // Pixel clock, syncs and data share one delay so they stay aligned
  pcc_sync #(.W(SYNC_W)) u_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .raw({FIELD_INDICATOR, FRAME_SYNC, LINE_SYNC, PIXEL_CLOCK_IN, SENSOR_DATA}), // R11
    .s(sif.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master clock divider
  logic [7:0] div_q;
  logic mclk_en;
  logic mclk_q;

  assign mclk_en = (div_q == MCLK_HALF);

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      div_q <= 8'h00;
    end else if (mclk_en) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      mclk_q <= 1'b0;
    end else if (mclk_en) begin
      mclk_q <= ~mclk_q; // R11
    end
  end

  assign SENSOR_MCLK = mclk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the filtered link signals
  logic pclk_q;
  logic lsync_q;
  logic fsync_q;
  logic pclk_rise;
  logic fs_rise;
  logic ls_rise;
  logic ls_fall;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pclk_q <= 1'b0;
      lsync_q <= 1'b0;
      fsync_q <= 1'b0;
    end else begin
      pclk_q <= sif.pclk;
      lsync_q <= sif.lsync;
      fsync_q <= sif.fsync;
    end
  end

  assign pclk_rise = sif.pclk & ~pclk_q; // R13
  assign fs_rise = sif.fsync & ~fsync_q;
  assign ls_rise = sif.lsync & ~lsync_q;
  assign ls_fall = ~sif.lsync & lsync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame alignment
  logic armed_q;
  logic first_q;
  logic field_q;
  logic [LINE_W-1:0] line_q;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      armed_q <= 1'b0;
    end else if (fs_rise) begin
      armed_q <= 1'b1; // R14
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      line_q <= '0;
    end else if (fs_rise) begin
      line_q <= '0; // R10
    end else if (ls_fall && armed_q) begin
      line_q <= line_q + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      field_q <= 1'b0;
    end else if (fs_rise) begin
      field_q <= sif.field; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Format decode
  logic take;
  logic [7:0] byte_in;
  logic [23:0] din;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] skip_q;
  logic [1:0] skip_d;
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  logic emit;
  logic [DATA_W-1:0] pix_d;

  assign take = pclk_rise & sif.lsync & armed_q; // R13 R14
  assign din = sif.data; // R1 R6
  assign byte_in = din[BYTE_HI:BYTE_LO]; // R3

  always_comb begin
    cnt_d = cnt_q;
    skip_d = skip_q;
    hold_d = hold_q;
    emit = 1'b0;
    pix_d = RESET_PIX;
    case (FORMAT) // R2
      PCC_FMT_RAW8: begin
        emit = 1'b1;
        pix_d = {16'h0000, byte_in}; // R3
      end
      PCC_FMT_GENERIC10: begin
        emit = 1'b1;
        pix_d = {14'h0000, din[9:0]}; // R4
      end
      PCC_FMT_CCIR656, PCC_FMT_YCC422_2C: begin
        // Timing reference codes in CCIR656 are dropped, not delivered
        if (skip_q != RESET_CNT) begin
          skip_d = skip_q - 2'h1;
        end else if (FORMAT == PCC_FMT_CCIR656 && byte_in == CCIR_PREAMBLE) begin
          skip_d = CCIR_SKIP;
          cnt_d = RESET_CNT;
        end else if (cnt_q == RESET_CNT) begin
          hold_d = {8'h00, byte_in}; // R9
          cnt_d = 2'h1;
        end else begin
          emit = 1'b1;
          pix_d = {byte_in, hold_q[7:0], 8'h00}; // R9
          cnt_d = RESET_CNT;
        end
      end
      PCC_FMT_YCC422_1C: begin
        emit = 1'b1;
        pix_d = {din[15:8], din[7:0], 8'h00}; // R5
      end
      PCC_FMT_RGB565_1C: begin
        emit = 1'b1;
        pix_d = {din[15:11], 3'h0, din[10:5], 2'h0, din[4:0], 3'h0}; // R5
      end
      PCC_FMT_RGB888_3C: begin
        if (cnt_q == 2'h2) begin
          emit = 1'b1;
          pix_d = {hold_q, byte_in}; // R8
          cnt_d = RESET_CNT;
        end else begin
          hold_d = {hold_q[7:0], byte_in}; // R8
          cnt_d = cnt_q + 2'h1;
        end
      end
      PCC_FMT_RGB888_1C, PCC_FMT_TVDEC_1C: begin
        emit = 1'b1;
        pix_d = {din[23:16], din[15:8], din[7:0]}; // R7
      end
      default: begin
        emit = 1'b0;
      end
    endcase
  end

  // Phase restarts with every line so a lost byte cannot skew later lines
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cnt_q <= RESET_CNT;
      skip_q <= RESET_CNT;
      hold_q <= 16'h0000;
    end else if (ls_rise || fs_rise) begin
      cnt_q <= RESET_CNT;
      skip_q <= RESET_CNT;
    end else if (take) begin
      cnt_q <= cnt_d;
      skip_q <= skip_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic valid_q;
  logic [DATA_W-1:0] pix_q;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= take & emit; // R13
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pix_q <= RESET_PIX;
    end else if (take && emit) begin
      pix_q <= pix_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      first_q <= 1'b0;
    end else if (fs_rise) begin
      first_q <= 1'b1; // R10
    end else if (valid_q) begin
      first_q <= 1'b0;
    end
  end

  assign PIX_VALID = valid_q;
  assign PIX_DATA = pix_q;
  assign PIX_FRAME_START = valid_q & first_q;
  assign PIX_FIELD = field_q;
  assign PIX_LINE = line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  chk_no_early_pix: assert property (PIX_VALID |-> $past(armed_q)) // R14
    else $error("pixel before first frame sync");
  chk_active_line: assert property (PIX_VALID |-> $past(pclk_rise && sif.lsync)) // R13
    else $error("pixel outside active line edge");
  chk_rgb_one_cycle: assert property (
    take && FORMAT == PCC_FMT_RGB888_1C |=> PIX_VALID && PIX_DATA == $past(din)) // R7
    else $error("one-cycle RGB888 mapping wrong");
  chk_three_bytes: assert property (
    PIX_VALID && $past(FORMAT) == PCC_FMT_RGB888_3C |-> $past(cnt_q) == 2'h2) // R8
    else $error("three-cycle pixel emitted early");
  chk_ycc_pair: assert property (
    take && FORMAT == PCC_FMT_YCC422_2C && cnt_q == 2'h1 && !ls_rise && !fs_rise
    |=> PIX_VALID && PIX_DATA[23:16] == $past(byte_in) && PIX_DATA[7:0] == 8'h00) // R9
    else $error("two-cycle luma not paired");
  chk_frame_realign: assert property (fs_rise |=> PIX_LINE == '0 && first_q) // R10
    else $error("frame sync did not realign");
  chk_mclk_toggle: assert property (mclk_en |=> SENSOR_MCLK != $past(SENSOR_MCLK)) // R11
    else $error("master clock did not toggle");
  chk_field_capture: assert property (fs_rise |=> PIX_FIELD == $past(sif.field)) // R12
    else $error("field not taken at frame start");
  chk_generic_width: assert property (
    PIX_VALID && $past(FORMAT) == PCC_FMT_GENERIC10 |-> PIX_DATA[23:10] == 14'h0000) // R4
    else $error("generic 10-bit width wrong");
  chk_mclk_period: assert property ($rose(SENSOR_MCLK) |-> ##[1:20] $fell(SENSOR_MCLK)) // R11
    else $error("master clock stuck high");
endmodule : pcc_capture
`default_nettype wire

// ===== pcc_sensor.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_sensor (
  input wire logic mclk,
  output logic pclk,
  output logic lsync,
  output logic fsync,
  output logic field,
  output logic [23:0] data
);
  initial begin
    pclk = 1'b0;
    lsync = 1'b0;
    fsync = 1'b0;
    field = 1'b0;
    data = 24'h000000;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic fld);
    @(posedge mclk);
    field <= fld;
    @(posedge mclk);
    fsync <= 1'b1;
    repeat (2) @(posedge mclk);
    fsync <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : frame
  // Pixel clock stands low outside lines, never free-running
  task automatic line(input logic act, input logic [23:0] w[$]);
    @(posedge mclk);
    lsync <= act;
    foreach (w[i]) begin
      @(posedge mclk);
      pclk <= 1'b0;
      data <= w[i];
      @(posedge mclk);
      pclk <= 1'b1;
    end
    @(posedge mclk);
    pclk <= 1'b0;
    // Released bus inverted so a stale sample cannot match
    @(posedge mclk);
    lsync <= 1'b0;
    data <= ~data;
    repeat (2) @(posedge mclk);
  endtask : line
endmodule : pcc_sensor
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcc_pkg::*;
  logic sys_clk, nrst, pclk, lsync, fsync, field, mclk, pv, pfs, pfld;
  logic [23:0] sdata, pdata;
  logic [11:0] pline;
  pcc_fmt_e fmt;
  int error_cnt, n_compared;
  logic [36:0] got_q[$];
  time t0;

  pcc_capture #(.MCLK_HALF(MCLK_HALF_M1)) i_pcc_capture (
    .SYS_CLK(sys_clk), .NRST(nrst), .PIXEL_CLOCK_IN(pclk), .LINE_SYNC(lsync),
    .FRAME_SYNC(fsync), .FIELD_INDICATOR(field), .SENSOR_DATA(sdata), .FORMAT(fmt),
    .SENSOR_MCLK(mclk), .PIX_VALID(pv), .PIX_DATA(pdata), .PIX_FRAME_START(pfs),
    .PIX_FIELD(pfld), .PIX_LINE(pline));
  pcc_sensor i_pcc_sensor (
    .mclk(mclk), .pclk(pclk), .lsync(lsync), .fsync(fsync), .field(field), .data(sdata));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (pv === 1'b1) begin
      got_q.push_back({pfs, pline, pdata});
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [36:0] g, input logic [36:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Byte lanes sit on 9:2; other bits noisy to prove they are ignored
  function automatic logic [23:0] ob(input logic [7:0] b);
    return {14'h2a5, b, 2'b11};
  endfunction : ob
  function automatic logic [23:0] exp1(input pcc_fmt_e f, input logic [23:0] d);
    case (f)
      PCC_FMT_YCC422_1C: return {d[15:0], 8'h00};
      PCC_FMT_RGB565_1C: return {d[15:11], 3'h0, d[10:5], 2'h0, d[4:0], 3'h0};
      PCC_FMT_RAW8: return {16'h0000, d[9:2]};
      PCC_FMT_GENERIC10: return {14'h0000, d[9:0]};
      default: return d;
    endcase
  endfunction : exp1
  task automatic run(input pcc_fmt_e f, input logic [23:0] w[$], input logic [23:0] e[$]);
    @(posedge sys_clk);
    fmt <= f;
    got_q.delete();
    i_pcc_sensor.frame(1'b0);
    i_pcc_sensor.line(1'b1, w);
    repeat (20) @(posedge sys_clk);
    chk(37'(got_q.size()), 37'(e.size()));
    foreach (e[i]) chk(got_q[i], {i == 0, 12'h000, e[i]});
  endtask : run
  task automatic runb(input pcc_fmt_e f, input logic [7:0] b[$], input logic [23:0] e[$]);
    logic [23:0] w[$];
    foreach (b[i]) w.push_back(ob(b[i]));
    run(f, w, e);
  endtask : runb
  //////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    @(posedge mclk);
    t0 = $time;
    @(posedge mclk);
    chk(37'(($time - t0) / 10), 37'(2 * (MCLK_HALF_M1 + 1)));
    got_q.delete();
    i_pcc_sensor.line(1'b1, '{24'h123456, 24'hfedcba});
    repeat (20) @(posedge sys_clk);
    chk(37'(got_q.size()), 37'h0);
    $display("test start done");
  endtask : t_start
  task automatic t_one_cycle;
    pcc_fmt_e fl[6];
    fl = '{PCC_FMT_RGB888_1C, PCC_FMT_TVDEC_1C, PCC_FMT_YCC422_1C,
           PCC_FMT_RGB565_1C, PCC_FMT_RAW8, PCC_FMT_GENERIC10};
    foreach (fl[i]) begin
      run(fl[i], '{24'hf1e2d3, 24'h0c3b7a},
          '{exp1(fl[i], 24'hf1e2d3), exp1(fl[i], 24'h0c3b7a)});
    end
    $display("test one_cycle done");
  endtask : t_one_cycle
  task automatic t_bytes;
    runb(PCC_FMT_YCC422_2C, '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a},
         '{24'h341200, 24'h785600});
    runb(PCC_FMT_CCIR656, '{8'hff, 8'h00, 8'h00, 8'h80, 8'h12, 8'h34},
         '{24'h341200});
    runb(PCC_FMT_RGB888_3C, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77},
         '{24'h112233, 24'h445566});
    $display("test bytes done");
  endtask : t_bytes
  task automatic t_lines;
    @(posedge sys_clk);
    fmt <= PCC_FMT_RAW8;
    got_q.delete();
    i_pcc_sensor.frame(1'b1);
    i_pcc_sensor.line(1'b0, '{ob(8'h01)});
    i_pcc_sensor.line(1'b1, '{ob(8'h5a)});
    i_pcc_sensor.line(1'b1, '{ob(8'ha5)});
    repeat (20) @(posedge sys_clk);
    chk(37'(got_q.size()), 37'h2);
    chk(got_q[0], {1'b1, 12'h000, 24'h00005a});
    chk(got_q[1], {1'b0, 12'h001, 24'h0000a5});
    chk(37'(pfld), 37'h1);
    i_pcc_sensor.frame(1'b0);
    chk(37'(pline), 37'h0);
    chk(37'(pfld), 37'h0);
    $display("test lines done");
  endtask : t_lines
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    fmt = PCC_FMT_RAW8;
    error_cnt = 0;
    n_compared = 0;
    repeat (15) @(posedge sys_clk);
    chk(37'({pv, mclk, pdata}), 37'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    t_start();
    t_one_cycle();
    t_bytes();
    t_lines();
    complete_run();
  end
  // Tests take about 2k cycles; allow roughly twenty-five times that
  initial begin
    #500000;
    error_cnt++;
    $display("watchdog expired");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
